// >>> pkg/sbm_pkg.sv
// shared constants for the single cycle byte multiplier
package sbm_pkg;
	localparam int          OPERAND_W     = 8;
	localparam int          PRODUCT_W     = 16;
	localparam int          FLAG_W        = 8;
	localparam int          FILE_ADDR_W   = 8;
	localparam int          PROD_LOW_LSB  = 0;
	localparam int          PROD_HIGH_LSB = 8;
	localparam int          MUL_CYCLES    = 1;
	localparam logic [7:0]  PROD_BYTE_RST = 8'h00;
	localparam logic [7:0]  FLAG_RST      = 8'h00;
	localparam logic [7:0]  ADDR_RST      = 8'h00;
endpackage

// >>> pkg/sbm_mul_if.sv
// operand and product carrier between the multiplier wrapper and its array
`timescale 1ns/1ps
interface sbm_mul_if #(
	parameter int OW = 8
);
	logic [OW-1:0]   opa;
	logic [OW-1:0]   opb;
	logic [2*OW-1:0] product;

	modport requester (
		output opa,
		output opb,
		input  product
	);
	modport array (
		input  opa,
		input  opb,
		output product
	);
endinterface

// >>> design/sbm_mul_array.sv
// combinational unsigned multiplier array built from shifted partial products
`timescale 1ns/1ps
module sbm_mul_array #(
	parameter int OW = 8
) (
	sbm_mul_if.array m
);
	import sbm_pkg::*;

	function automatic logic [2*OW-1:0] partial_row(
		input logic [OW-1:0] a,
		input logic          bit_b,
		input int            shift
	);
		logic [2*OW-1:0] wide;
		wide = {{OW{1'b0}}, a};
		partial_row = bit_b ? (wide << shift) : '0;
	endfunction

	logic [2*OW-1:0] next_sum;

	always_comb begin
		next_sum = '0;
		for (int i = 0; i < OW; i++) begin
			next_sum = next_sum + partial_row(m.opa, m.opb[i], i);
		end
	end

	assign m.product = next_sum;
endmodule

// >>> design/sbm_mul_unit.sv
// byte multiplier with product register pair and alu flags that a multiply leaves untouched
`timescale 1ns/1ps
module sbm_mul_unit #(
	parameter int OW = sbm_pkg::OPERAND_W
) (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           multiply_accumulator_by_file_op,
	input  wire logic [sbm_pkg::OPERAND_W-1:0]   working_accumulator,
	input  wire logic [sbm_pkg::FILE_ADDR_W-1:0] file_addr,
	input  wire logic [sbm_pkg::OPERAND_W-1:0]   file_rdata,
	input  wire logic                           high_wr_en,
	input  wire logic                           low_wr_en,
	input  wire logic [7:0]                     byte_wdata,
	input  wire logic                           flag_wr_en,
	input  wire logic [sbm_pkg::FLAG_W-1:0]      flag_wdata,
	output logic      [7:0]                     product_high_byte,
	output logic      [7:0]                     product_low_byte,
	output logic      [sbm_pkg::FLAG_W-1:0]      alu_flag_register,
	output logic      [sbm_pkg::FILE_ADDR_W-1:0] last_file_addr,
	output logic                                mul_done
);
	import sbm_pkg::*;

	sbm_mul_if #(.OW(OW)) mif ();

	logic [2*OW-1:0] product_word;
	logic [7:0]      next_high;
	logic [7:0]      next_low;
	logic [7:0]      next_flags;
	logic [7:0]      next_last_addr;
	logic            do_mul;

	// reference product for the checks below
	function automatic logic [2*OW-1:0] ref_product(
		input logic [OW-1:0] a,
		input logic [OW-1:0] b
	);
		ref_product = {{OW{1'b0}}, a} * {{OW{1'b0}}, b};
	endfunction

	assign mif.opa = working_accumulator[OW-1:0];
	assign mif.opb = file_rdata[OW-1:0];

	sbm_mul_array #(
		.OW (OW)
	) u_array (
		.m (mif.array)
	);

	assign product_word = mif.product;
	assign do_mul       = multiply_accumulator_by_file_op;

	assign next_high = do_mul     ? product_word[PROD_HIGH_LSB +: 8] :
	                   high_wr_en ? byte_wdata : product_high_byte;
	assign next_low  = do_mul     ? product_word[PROD_LOW_LSB +: 8] :
	                   low_wr_en  ? byte_wdata : product_low_byte;

	assign next_flags = (flag_wr_en && !do_mul) ? flag_wdata : alu_flag_register;

	// product pair latched at cycle end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			product_high_byte <= PROD_BYTE_RST;
			product_low_byte  <= PROD_BYTE_RST;
		end else begin
			product_high_byte <= next_high;
			product_low_byte  <= next_low;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alu_flag_register <= FLAG_RST;
		end else begin
			alu_flag_register <= next_flags;
		end
	end

	assign next_last_addr = do_mul ? file_addr : last_file_addr;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_file_addr <= ADDR_RST;
		end else begin
			last_file_addr <= next_last_addr;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mul_done <= 1'b0;
		end else begin
			mul_done <= do_mul;
		end
	end

	// helper: operand copies for checking
	logic [OW-1:0]   chk_a;
	logic [OW-1:0]   chk_b;
	logic [2*OW-1:0] chk_prod;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chk_a <= '0;
			chk_b <= '0;
		end else begin
			chk_a <= working_accumulator[OW-1:0];
			chk_b <= file_rdata[OW-1:0];
		end
	end

	assign chk_prod = ref_product(chk_a, chk_b);

	AST_DONE_ONE_CYCLE: assert property (
		@(posedge clk) disable iff (!rst_n)
		multiply_accumulator_by_file_op |=> mul_done
	) else $error("multiply did not finish in one cycle");

	AST_NO_SPURIOUS_DONE: assert property (
		@(posedge clk) disable iff (!rst_n)
		!multiply_accumulator_by_file_op |=> !mul_done
	) else $error("done raised without a multiply");

	AST_FULL_PRODUCT: assert property (
		@(posedge clk) disable iff (!rst_n)
		mul_done |-> {product_high_byte, product_low_byte} == chk_prod
	) else $error("product pair is not the full unsigned product");

	AST_ZERO_OPERAND: assert property (
		@(posedge clk) disable iff (!rst_n)
		multiply_accumulator_by_file_op
		&& (working_accumulator == 8'h00 || file_rdata == 8'h00)
		|=> {product_high_byte, product_low_byte} == 16'h0000
	) else $error("zero operand gave a nonzero product");

	AST_UNIT_OPERAND: assert property (
		@(posedge clk) disable iff (!rst_n)
		multiply_accumulator_by_file_op && working_accumulator == 8'h01
		|=> {product_high_byte, product_low_byte} == {8'h00, $past(file_rdata)}
	) else $error("unit operand did not pass the file operand through");

	AST_HIGH_BOUND: assert property (
		@(posedge clk) disable iff (!rst_n)
		mul_done |-> product_high_byte <= chk_a
	) else $error("high product byte exceeds the accumulator operand");

	AST_HIGH_BYTE: assert property (
		@(posedge clk) disable iff (!rst_n)
		multiply_accumulator_by_file_op
		|=> product_high_byte == chk_prod[PROD_HIGH_LSB +: 8]
	) else $error("high product byte holds the wrong half");

	AST_LOW_BYTE: assert property (
		@(posedge clk) disable iff (!rst_n)
		multiply_accumulator_by_file_op
		|=> product_low_byte == chk_prod[PROD_LOW_LSB +: 8]
	) else $error("low product byte holds the wrong half");

	AST_MUL_BEATS_WRITE: assert property (
		@(posedge clk) disable iff (!rst_n)
		multiply_accumulator_by_file_op && (high_wr_en || low_wr_en)
		|=> {product_high_byte, product_low_byte} == chk_prod
	) else $error("direct byte write won over a multiply");

	AST_DIRECT_HIGH: assert property (
		@(posedge clk) disable iff (!rst_n)
		!multiply_accumulator_by_file_op && high_wr_en
		|=> product_high_byte == $past(byte_wdata)
	) else $error("direct write to the high product byte lost");

	AST_DIRECT_LOW: assert property (
		@(posedge clk) disable iff (!rst_n)
		!multiply_accumulator_by_file_op && low_wr_en
		|=> product_low_byte == $past(byte_wdata)
	) else $error("direct write to the low product byte lost");

	AST_FLAGS_KEPT: assert property (
		@(posedge clk) disable iff (!rst_n)
		multiply_accumulator_by_file_op |=> $stable(alu_flag_register)
	) else $error("multiply changed the alu flags");

	AST_FLAG_WRITE_TAKEN: assert property (
		@(posedge clk) disable iff (!rst_n)
		flag_wr_en && !multiply_accumulator_by_file_op
		|=> alu_flag_register == $past(flag_wdata)
	) else $error("flag write outside a multiply was lost");

	AST_FLAGS_ONLY_BY_WRITE: assert property (
		@(posedge clk) disable iff (!rst_n)
		!flag_wr_en |=> $stable(alu_flag_register)
	) else $error("alu flags changed without a flag write");

	AST_OPERAND_SOURCE: assert property (
		@(posedge clk) disable iff (!rst_n)
		multiply_accumulator_by_file_op
		|=> last_file_addr == $past(file_addr)
		    && {product_high_byte, product_low_byte}
		       == ref_product($past(working_accumulator), $past(file_rdata))
	) else $error("operands not taken from accumulator and file location");

	AST_LAST_ADDR_HELD: assert property (
		@(posedge clk) disable iff (!rst_n)
		!multiply_accumulator_by_file_op |=> $stable(last_file_addr)
	) else $error("file address changed without a multiply");

	AST_HELD_FOR_NEXT: assert property (
		@(posedge clk) disable iff (!rst_n)
		mul_done && !multiply_accumulator_by_file_op && !high_wr_en && !low_wr_en
		|=> $stable(product_high_byte) && $stable(product_low_byte)
	) else $error("product pair lost before the next instruction");

	AST_RESET_CLEARS: assert property (
		@(posedge clk)
		!rst_n
		|=> product_high_byte == PROD_BYTE_RST && product_low_byte == PROD_BYTE_RST
		    && alu_flag_register == FLAG_RST && last_file_addr == ADDR_RST && !mul_done
	) else $error("outputs not cleared by reset");
endmodule

// >>> tb/sbm_regfile_model.sv
// register file stand-in that returns the file operand for an address
`timescale 1ns/1ps
module sbm_regfile_model (
	input  wire logic [sbm_pkg::FILE_ADDR_W-1:0] file_addr,
	output logic      [sbm_pkg::OPERAND_W-1:0]   file_rdata
);
	import sbm_pkg::*;
	assign file_rdata = file_addr ^ 8'ha5;
endmodule

// >>> tb/single_cycle_byte_multiplier_tb_top.sv
// self-checking bench for the byte multiplier
`timescale 1ns/1ps
`define CHK(g,e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("Error %0t: got %h want %h", $time, g, e); end end
module single_cycle_byte_multiplier_tb_top;
	import sbm_pkg::*;
	logic       clk = 0, rst_n = 0, op = 0, hw = 0, lw = 0, fw = 0, done;
	logic [7:0] acc = 0, addr = 0, bd = 0, fd = 0, rd, hi, lo, fl, la;
	logic [7:0] e_hi = PROD_BYTE_RST, e_lo = PROD_BYTE_RST, e_fl = FLAG_RST, e_la = ADDR_RST;
	logic       e_done = 0;
	int         failures = 0, cmp_count = 0;
	always #5 clk = ~clk;
	sbm_regfile_model rf (.file_addr(addr), .file_rdata(rd));
	sbm_mul_unit uut (.clk(clk), .rst_n(rst_n), .multiply_accumulator_by_file_op(op),
		.working_accumulator(acc), .file_addr(addr), .file_rdata(rd), .high_wr_en(hw),
		.low_wr_en(lw), .byte_wdata(bd), .flag_wr_en(fw), .flag_wdata(fd),
		.product_high_byte(hi), .product_low_byte(lo), .alu_flag_register(fl),
		.last_file_addr(la), .mul_done(done));
	// one cycle of stimulus; checks the result of the previous cycle
	task automatic step(logic o, logic [7:0] a, logic [7:0] ad, logic h, logic l,
		logic f, logic [7:0] d);
		logic [15:0] p;
		op <= o;
		acc <= a;
		addr <= ad;
		hw <= h;
		lw <= l;
		fw <= f;
		bd <= d;
		fd <= d;
		@(posedge clk);
		`CHK(done, e_done)
		`CHK(hi, e_hi)
		`CHK(lo, e_lo)
		`CHK(fl, e_fl)
		`CHK(la, e_la)
		p = {8'h00, a} * {8'h00, ad ^ 8'ha5};
		e_done = o;
		if (o) begin
			e_hi = p[15:8];
			e_lo = p[7:0];
			e_la = ad;
		end else begin
			if (h) e_hi = d;
			if (l) e_lo = d;
			if (f) e_fl = d;
		end
	endtask
	// back to back multiplies on boundary operands
	task automatic t_corners();
		step(1, 8'hff, 8'h5a, 0, 0, 0, 8'h00);
		step(1, 8'h00, 8'h10, 0, 0, 0, 8'h00);
		step(1, 8'hff, 8'ha7, 0, 0, 0, 8'h00);
		step(1, 8'h01, 8'h5a, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
	endtask
	// flag write ignored during a multiply
	task automatic t_flags();
		step(0, 8'h00, 8'h00, 0, 0, 1, 8'h3c);
		step(1, 8'h12, 8'h34, 0, 0, 1, 8'hc3);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
	endtask
	// direct byte writes, then a multiply that wins over them
	task automatic t_direct();
		step(0, 8'h00, 8'h00, 1, 1, 0, 8'h55);
		step(1, 8'h7f, 8'h20, 1, 1, 0, 8'haa);
		step(0, 8'h00, 8'h00, 0, 1, 0, 8'h66);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
	endtask
	// signed correction applied in software on the product
	task automatic t_signed();
		step(1, 8'hfe, 8'h5a, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		`CHK({8'(hi - 8'hff - 8'hfe), lo}, 16'h0002)
		step(1, 8'h05, 8'h58, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		`CHK({8'(hi - 8'h05), lo}, 16'hfff1)
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
	endtask
	// sixteen by sixteen product from four byte products
	task automatic t_wide();
		logic [31:0] res;
		res = 32'h0000_0000;
		step(1, 8'h3e, 8'ha1 ^ 8'ha5, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		res = {16'h0000, hi, lo};
		step(1, 8'h9c, 8'hd7 ^ 8'ha5, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		res = res + {hi, lo, 16'h0000};
		step(1, 8'h3e, 8'hd7 ^ 8'ha5, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		res = res + {8'h00, hi, lo, 8'h00};
		step(1, 8'h9c, 8'ha1 ^ 8'ha5, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		res = res + {8'h00, hi, lo, 8'h00};
		`CHK(res, 32'h9c3e * 32'hd7a1)
	endtask
	// mid-run reset clears pair, flags and address, then a multiply at once
	task automatic t_reset();
		step(1, 8'hc8, 8'h3b, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 1, 8'h99);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		rst_n <= 1'b0;
		e_hi = PROD_BYTE_RST;
		e_lo = PROD_BYTE_RST;
		e_fl = FLAG_RST;
		e_la = ADDR_RST;
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		rst_n <= 1'b1;
		step(1, 8'h21, 8'h44, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
		step(0, 8'h00, 8'h00, 0, 0, 0, 8'h00);
	endtask
	task automatic finish_test();
		$display("failures %0d compares %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		failures++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		t_corners();
		t_flags();
		t_direct();
		t_signed();
		t_wide();
		t_reset();
		finish_test();
	end
endmodule
